/* File: serial_framer_pkg.sv */
// Purpose: shared constants and types of the serial message framer
// Assumes: 50 MHz clock, APB register access, one aligned word per register
// Notes:   reset values are the static port configuration
package serial_framer_pkg;

  localparam int unsigned CLK_HZ      = 50_000_000;
  localparam int unsigned DELAY_MS    = 1;
  localparam int unsigned MS_CYCLES   = CLK_HZ / 1000 * DELAY_MS;
  localparam int unsigned BREAK_CAP_S = 8;
  localparam int unsigned CAP_CYCLES  = BREAK_CAP_S * CLK_HZ;

  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_RTS_DLY = 8'h04;
  localparam logic [7:0] OFS_BITS    = 8'h08;
  localparam logic [7:0] OFS_BAUD    = 8'h0C;
  localparam logic [7:0] OFS_RX_CFG  = 8'h10;
  localparam logic [7:0] OFS_STATUS  = 8'h14;
  localparam logic [7:0] OFS_RX_DATA = 8'h18;
  localparam logic [7:0] OFS_TX_DATA = 8'h1C;

  localparam int unsigned CTRL_REARM_BIT = 8;
  localparam int unsigned RXD_VALID_BIT  = 8;

  localparam logic [6:0]  CTRL_RST    = 7'h08;
  localparam logic [31:0] RTS_DLY_RST = 32'h0000_0000;
  localparam logic [31:0] BITS_RST    = 32'h000C_000C;
  localparam logic [15:0] BAUD_RST    = 16'h1458;
  localparam logic [31:0] RX_CFG_RST  = 32'h000C_0002;

  typedef struct packed {
    logic rx_char;
    logic rx_idle;
    logic rx_brk;
    logic rx_any;
    logic idle_en;
    logic break_en;
    logic hw_flow;
  } ctrl_s;

  typedef struct packed {
    logic       ferr;
    logic [7:0] data;
  } rx_char_s;

  typedef enum logic [2:0] {
    TX_IDLE   = 3'b000,
    TX_RTS_ON = 3'b001,
    TX_CTS    = 3'b011,
    TX_BREAK  = 3'b010,
    TX_MARK   = 3'b110,
    TX_DATA   = 3'b111,
    TX_RTS_OF = 3'b101
  } tx_state_e;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_BRK  = 2'b01,
    S_CHR  = 2'b11,
    S_MSG  = 2'b10
  } srch_e;

endpackage

/* File: rx_pair_buffer.sv */
// Purpose: small FIFO between receiver and register read port
// Assumes: single clock, in and out handshakes are valid/ready
// Notes:   honest full/empty; a full buffer drops in_ready
`timescale 1ns/1ps
module rx_pair_buffer #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 2
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             in_valid,
  output      logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output      logic             out_valid,
  input  wire logic             out_ready,
  output      logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  a_no_overfill: assert property (@(posedge clk) disable iff (!resetn)
    count <= (AW+1)'(DEPTH)) else $error("buffer count beyond depth");

endmodule

/* File: serial_message_framer.sv */
// Purpose: message framing for an async serial port: rts/cts sequencing,
//          break and idle preamble on send, start-of-message search on receive
// Assumes: 50 MHz clk, APB slave with zero wait states, 8N1 characters
// Notes:   runtime register writes override the static reset configuration
`timescale 1ns/1ps
// Overview of operation
// (RL1) after raising rts, wait the rts-on delay in ms before sending
// (RL2) cts is looked at only after the rts-on delay has run out
// (RL3) rts delays count only when hardware flow control is selected
// (RL4) after the last character, hold rts for the rts-off delay in ms
// (RL5) break at message start is sent after rts-on delay and active cts
// (RL6) break holds line low for set bit times, never over eight seconds
// (RL7) idle line holds line high for set bit times after the break
// (RL8) values written by software override the static configuration
// (RL9) written values are lost at reset; static configuration returns
// (RL10) start characters and later message characters go to receive buffer
// (RL11) with several start conditions, all must be met before message starts
// (RL12) a wrong character during combined search restarts at first condition
// (RL13) any-character start: first error-free character starts and is stored
// (RL14) line-break start: a received break character starts the receive
// (RL15) idle-line start: quiet line for set bit times; characters restart timer
// (RL16) conditions checked in order idle line, line break, then start character
// (RL17) single start character: earlier characters dropped, match stored first
// (RL18) break and idle lengths are counted in bit periods from the baud divider
// (RL19) break then idle preamble complete before any data character is sent
module serial_message_framer #(
  parameter int unsigned MS_CYCLES  = serial_framer_pkg::MS_CYCLES,
  parameter int unsigned CAP_CYCLES = serial_framer_pkg::CAP_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  input  wire logic        cts,
  input  wire logic        rxd,
  output      logic        rts,
  output      logic        txd
);
  serial_framer_pkg::ctrl_s     ctl;
  logic [31:0]                  rts_dly;
  logic [31:0]                  bit_times;
  logic [15:0]                  baud;
  logic [31:0]                  rx_cfg;
  serial_framer_pkg::tx_state_e tx_state;
  serial_framer_pkg::tx_state_e next_tx_state;
  serial_framer_pkg::srch_e     srch;
  serial_framer_pkg::srch_e     next_srch;
  logic        wr_en, rd_acc, mapped;
  logic [7:0]  hold;
  logic        hold_valid;
  logic        cts_m, cts_s, rxd_m, rxd_s;
  logic        phase_chg, unit_tick, tx_tick, ms_tick, cap_hit, done;
  logic [15:0] target, tx_cnt, ms_pre, tx_div;
  logic [28:0] cap_cnt;
  logic [9:0]  sh;
  logic [3:0]  sh_bits;
  logic        load;
  logic        rx_busy, rx_done;
  logic [15:0] rx_div, idle_div, idle_cnt;
  logic [3:0]  rx_bit;
  logic [9:0]  rx_sh;
  serial_framer_pkg::rx_char_s rx_ch;
  logic        idle_met, is_brk, match, push_valid, push_ready, overrun, rearm;
  logic        out_valid;
  logic [7:0]  out_data;

  // first search stage; fixed order idle, break, character
  function automatic serial_framer_pkg::srch_e first_cond(serial_framer_pkg::ctrl_s c);
    if (c.rx_idle) begin
      return serial_framer_pkg::S_IDLE;
    end else if (c.rx_brk) begin
      return serial_framer_pkg::S_BRK;
    end else begin
      return serial_framer_pkg::S_CHR;
    end
  endfunction

  // ---------------- APB slave ----------------
  assign pready = 1'b1;
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= serial_framer_pkg::OFS_TX_DATA);
  assign pslverr = psel && penable && !mapped;
  assign wr_en  = psel && penable && pwrite && mapped;
  assign rd_acc = psel && penable && !pwrite && (paddr == serial_framer_pkg::OFS_RX_DATA);
  assign rearm  = wr_en && (paddr == serial_framer_pkg::OFS_CTRL) &&
                  pwdata[serial_framer_pkg::CTRL_REARM_BIT];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctl       <= serial_framer_pkg::CTRL_RST; // RL9
      rts_dly   <= serial_framer_pkg::RTS_DLY_RST;
      bit_times <= serial_framer_pkg::BITS_RST;
      baud      <= serial_framer_pkg::BAUD_RST;
      rx_cfg    <= serial_framer_pkg::RX_CFG_RST;
    end else if (wr_en) begin
      case (paddr) // RL8
        serial_framer_pkg::OFS_CTRL:    ctl       <= pwdata[6:0];
        serial_framer_pkg::OFS_RTS_DLY: rts_dly   <= pwdata;
        serial_framer_pkg::OFS_BITS:    bit_times <= pwdata;
        serial_framer_pkg::OFS_BAUD:    baud      <= (pwdata[15:0] < 16'h0002) ? 16'h0002 : pwdata[15:0];
        serial_framer_pkg::OFS_RX_CFG:  rx_cfg    <= pwdata;
        default: ;
      endcase
    end
  end

  // read data is captured in the setup phase so prdata comes from a flop
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        serial_framer_pkg::OFS_CTRL:    prdata <= {25'h0000000, ctl};
        serial_framer_pkg::OFS_RTS_DLY: prdata <= rts_dly;
        serial_framer_pkg::OFS_BITS:    prdata <= bit_times;
        serial_framer_pkg::OFS_BAUD:    prdata <= {16'h0000, baud};
        serial_framer_pkg::OFS_RX_CFG:  prdata <= rx_cfg;
        serial_framer_pkg::OFS_STATUS:
          prdata <= {25'h0000000, hold_valid, overrun, srch, tx_state};
        serial_framer_pkg::OFS_RX_DATA: prdata <= {23'h000000, out_valid, out_data};
        default:                        prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------- pin synchronisers ----------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cts_m <= 1'b0;
      cts_s <= 1'b0;
      rxd_m <= 1'b1;
      rxd_s <= 1'b1;
    end else begin
      cts_m <= cts;
      cts_s <= cts_m;
      rxd_m <= rxd;
      rxd_s <= rxd_m;
    end
  end

  // ---------------- transmit holding register ----------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hold       <= 8'h00;
      hold_valid <= 1'b0;
    end else if (wr_en && paddr == serial_framer_pkg::OFS_TX_DATA) begin
      hold       <= pwdata[7:0];
      hold_valid <= 1'b1;
    end else if (load) begin
      hold_valid <= 1'b0;
    end
  end

  // ---------------- transmit sequencing ----------------
  assign phase_chg = (next_tx_state != tx_state);
  assign ms_tick   = (ms_pre == 16'(MS_CYCLES - 1));
  assign tx_tick   = (tx_div == baud - 16'h0001); // RL18
  assign cap_hit   = (cap_cnt >= 29'(CAP_CYCLES - 1));
  assign load      = (tx_state == serial_framer_pkg::TX_DATA) && tx_tick && (sh_bits == 4'h0) &&
                     hold_valid && (!ctl.hw_flow || cts_s);

  always_comb begin
    unit_tick = 1'b0;
    target    = 16'h0000;
    case (tx_state)
      serial_framer_pkg::TX_RTS_ON: begin
        unit_tick = ms_tick;
        target    = ctl.hw_flow ? rts_dly[15:0] : 16'h0000; // RL1 RL3
      end
      serial_framer_pkg::TX_RTS_OF: begin
        unit_tick = ms_tick;
        target    = ctl.hw_flow ? rts_dly[31:16] : 16'h0000; // RL4 RL3
      end
      serial_framer_pkg::TX_BREAK: begin
        unit_tick = tx_tick;
        target    = ctl.break_en ? bit_times[15:0] : 16'h0000; // RL6
      end
      serial_framer_pkg::TX_MARK: begin
        unit_tick = tx_tick;
        target    = ctl.idle_en ? bit_times[31:16] : 16'h0000; // RL7
      end
      default: ;
    endcase
  end

  // the unit that reaches the target ends the phase at once; the cap cuts a long break or idle
  assign done = (tx_cnt >= target) || (unit_tick && (tx_cnt + 16'h0001 == target)) ||
                (cap_hit && (tx_state == serial_framer_pkg::TX_BREAK ||
                             tx_state == serial_framer_pkg::TX_MARK)); // RL6 RL7

  always_comb begin
    next_tx_state = tx_state;
    case (tx_state)
      serial_framer_pkg::TX_IDLE:
        if (hold_valid) next_tx_state = serial_framer_pkg::TX_RTS_ON;
      serial_framer_pkg::TX_RTS_ON:
        if (done) next_tx_state = serial_framer_pkg::TX_CTS; // RL1
      serial_framer_pkg::TX_CTS:
        if (!ctl.hw_flow || cts_s) next_tx_state = serial_framer_pkg::TX_BREAK; // RL2 RL5
      serial_framer_pkg::TX_BREAK:
        if (done) next_tx_state = serial_framer_pkg::TX_MARK; // RL19
      serial_framer_pkg::TX_MARK:
        if (done) next_tx_state = serial_framer_pkg::TX_DATA; // RL19
      serial_framer_pkg::TX_DATA:
        if (tx_tick && sh_bits == 4'h0 && !hold_valid) next_tx_state = serial_framer_pkg::TX_RTS_OF;
      serial_framer_pkg::TX_RTS_OF:
        if (done) next_tx_state = serial_framer_pkg::TX_IDLE; // RL4
      default: next_tx_state = serial_framer_pkg::TX_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_state <= serial_framer_pkg::TX_IDLE;
    end else begin
      tx_state <= next_tx_state;
    end
  end

  // every phase but the data phase restarts its dividers so its first unit is a whole one
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_cnt  <= 16'h0000;
      ms_pre  <= 16'h0000;
      tx_div  <= 16'h0000;
      cap_cnt <= 29'h00000000;
    end else if (phase_chg) begin
      tx_cnt  <= 16'h0000;
      ms_pre  <= 16'h0000;
      // data phase ticks at once so the start bit follows the idle line directly
      tx_div  <= (next_tx_state == serial_framer_pkg::TX_DATA) ? baud - 16'h0001 : 16'h0000;
      cap_cnt <= 29'h00000000;
    end else begin
      ms_pre  <= ms_tick ? 16'h0000 : ms_pre + 16'h0001;
      tx_div  <= tx_tick ? 16'h0000 : tx_div + 16'h0001;
      if (!cap_hit) cap_cnt <= cap_cnt + 29'h00000001;
      if (unit_tick && tx_cnt != 16'hFFFF) tx_cnt <= tx_cnt + 16'h0001;
    end
  end

  // rts stays up through the off delay; without flow control it rests low
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rts <= 1'b0;
    end else begin
      rts <= ctl.hw_flow && (tx_state != serial_framer_pkg::TX_IDLE); // RL1 RL4
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sh      <= 10'h3FF;
      sh_bits <= 4'h0;
      txd     <= 1'b1;
    end else if (tx_state == serial_framer_pkg::TX_BREAK) begin
      txd <= !ctl.break_en; // RL5 RL6
    end else if (tx_state != serial_framer_pkg::TX_DATA) begin
      txd <= 1'b1; // RL7
    end else if (tx_tick && sh_bits != 4'h0) begin
      txd     <= sh[0];
      sh      <= {1'b1, sh[9:1]};
      sh_bits <= sh_bits - 4'h1;
    end else if (load) begin
      txd     <= 1'b0;
      sh      <= {2'b11, hold};
      sh_bits <= 4'h9;
    end
  end

  // ---------------- receive deserialiser ----------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_busy <= 1'b0;
      rx_done <= 1'b0;
      rx_div  <= 16'h0000;
      rx_bit  <= 4'h0;
      rx_sh   <= 10'h000;
    end else begin
      rx_done <= 1'b0;
      if (!rx_busy) begin
        if (!rxd_s) begin
          rx_busy <= 1'b1;
          rx_div  <= {1'b0, baud[15:1]};
          rx_bit  <= 4'h0;
        end
      end else if (rx_div == 16'h0000) begin
        rx_div <= baud - 16'h0001;
        rx_sh  <= {rxd_s, rx_sh[9:1]};
        rx_bit <= rx_bit + 4'h1;
        if (rx_bit == 4'h0 && rxd_s) rx_busy <= 1'b0;
        if (rx_bit == 4'h9) begin
          rx_busy <= 1'b0;
          rx_done <= 1'b1;
        end
      end else begin
        rx_div <= rx_div - 16'h0001;
      end
    end
  end

  assign rx_ch  = {!rx_sh[9], rx_sh[8:1]};
  assign is_brk = rx_ch.ferr && (rx_ch.data == 8'h00); // RL14

  // quiet-line timer in bit periods, cleared by any line activity
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      idle_div <= 16'h0000;
      idle_cnt <= 16'h0000;
    end else if (rx_busy || !rxd_s) begin
      idle_div <= 16'h0000;
      idle_cnt <= 16'h0000; // RL15
    end else if (idle_div == baud - 16'h0001) begin
      idle_div <= 16'h0000;
      if (idle_cnt != 16'hFFFF) idle_cnt <= idle_cnt + 16'h0001; // RL18
    end else begin
      idle_div <= idle_div + 16'h0001;
    end
  end

  assign idle_met = (idle_cnt >= rx_cfg[31:16]);
  assign match    = !rx_ch.ferr && (!ctl.rx_char || rx_ch.data == rx_cfg[7:0]); // RL13 RL17

  // ---------------- start-of-message search ----------------
  always_comb begin
    next_srch = srch;
    case (srch)
      serial_framer_pkg::S_IDLE:
        if (idle_met) begin // RL15 RL16
          if (ctl.rx_brk) next_srch = serial_framer_pkg::S_BRK;
          else if (ctl.rx_char || ctl.rx_any) next_srch = serial_framer_pkg::S_CHR;
          else next_srch = serial_framer_pkg::S_MSG;
        end
      serial_framer_pkg::S_BRK:
        if (rx_done) begin
          if (!is_brk) next_srch = first_cond(ctl); // RL12
          else if (ctl.rx_char || ctl.rx_any) next_srch = serial_framer_pkg::S_CHR; // RL11
          else next_srch = serial_framer_pkg::S_MSG; // RL14
        end
      serial_framer_pkg::S_CHR:
        if (rx_done) next_srch = match ? serial_framer_pkg::S_MSG : first_cond(ctl); // RL12 RL17
      serial_framer_pkg::S_MSG:
        // rearm rides on a control write, so the written settings pick the first stage
        if (rearm) next_srch = first_cond(serial_framer_pkg::ctrl_s'(pwdata[6:0]));
      default: next_srch = serial_framer_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      srch <= serial_framer_pkg::S_CHR;
    end else begin
      srch <= next_srch;
    end
  end

  assign push_valid = rx_done && ((srch == serial_framer_pkg::S_CHR && match) ||
                                  srch == serial_framer_pkg::S_MSG); // RL10 RL13

  // a full buffer cannot stall the line; the lost character is flagged
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      overrun <= 1'b0;
    end else if (push_valid && !push_ready) begin
      overrun <= 1'b1;
    end else if (rearm) begin
      overrun <= 1'b0;
    end
  end

  rx_pair_buffer #(
    .WIDTH(8),
    .DEPTH(2)
  ) u_rx_buf (
    .clk       (clk),
    .resetn    (resetn),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (rx_ch.data),
    .out_valid (out_valid),
    .out_ready (rd_acc),
    .out_data  (out_data)
  );

  // ---------------- checks ----------------
  sequence s_mark_held;
    tx_state == serial_framer_pkg::TX_MARK ##1 tx_state == serial_framer_pkg::TX_MARK;
  endsequence

  a_rts_on_wait: assert property (@(posedge clk) disable iff (!resetn) // RL1
    (tx_state == serial_framer_pkg::TX_CTS && $past(tx_state) == serial_framer_pkg::TX_RTS_ON)
    |-> (!$past(ctl.hw_flow) ||
         ($past(tx_cnt) + {15'h0000, $past(ms_tick)}) >= $past(rts_dly[15:0])))
    else $error("rts-on delay cut short");
  a_cts_after_delay: assert property (@(posedge clk) disable iff (!resetn) // RL2
    (tx_state == serial_framer_pkg::TX_BREAK && $past(tx_state) == serial_framer_pkg::TX_CTS)
    |-> (!$past(ctl.hw_flow) || $past(cts_s)))
    else $error("left cts wait without cts");
  a_flow_off_skip: assert property (@(posedge clk) disable iff (!resetn) // RL3
    (tx_state == serial_framer_pkg::TX_RTS_ON && !ctl.hw_flow)
    |=> tx_state == serial_framer_pkg::TX_CTS)
    else $error("rts delay applied without flow control");
  a_rts_off_hold: assert property (@(posedge clk) disable iff (!resetn) // RL4
    (tx_state == serial_framer_pkg::TX_RTS_OF && $past(tx_state) == serial_framer_pkg::TX_RTS_OF
     && $past(ctl.hw_flow)) |-> rts)
    else $error("rts dropped during off delay");
  a_break_spacing: assert property (@(posedge clk) disable iff (!resetn) // RL6
    (tx_state == serial_framer_pkg::TX_BREAK && $past(tx_state) == serial_framer_pkg::TX_BREAK)
    |-> !txd) else $error("line not spacing during break");
  a_break_cap: assert property (@(posedge clk) disable iff (!resetn) // RL6
    tx_state == serial_framer_pkg::TX_BREAK |-> cap_cnt < 29'(CAP_CYCLES))
    else $error("break beyond eight seconds");
  a_idle_marking: assert property (@(posedge clk) disable iff (!resetn) // RL7
    s_mark_held |-> txd) else $error("line not marking during idle preamble");
  a_preamble_first: assert property (@(posedge clk) disable iff (!resetn) // RL19
    (tx_state == serial_framer_pkg::TX_DATA && $past(tx_state) != serial_framer_pkg::TX_DATA)
    |-> $past(tx_state) == serial_framer_pkg::TX_MARK)
    else $error("data began before preamble ended");
  a_search_restart: assert property (@(posedge clk) disable iff (!resetn) // RL12
    (srch == serial_framer_pkg::S_BRK && rx_done && !is_brk)
    |=> srch == $past(first_cond(ctl))) else $error("search did not restart");
  a_message_store: assert property (@(posedge clk) disable iff (!resetn) // RL10
    (srch == serial_framer_pkg::S_MSG && rx_done) |-> push_valid)
    else $error("message character not stored");

endmodule

/* File: remote_serial_peer.sv */
// Purpose: remote serial device facing the framer's pins
// Assumes: 8N1 characters of BIT_CYCLES clocks per bit
// Notes:   cts rises CTS_LAG clocks after rts, like a slow modem; it drops one clock after rts falls
`timescale 1ns/1ps
module remote_serial_peer #(
  parameter int unsigned BIT_CYCLES = 4,
  parameter int unsigned CTS_LAG    = 3
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic rts,
  output      logic cts,
  output      logic rxd
);
  int unsigned lag;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lag <= 0;
    end else if (!rts) begin
      lag <= 0;
    end else if (lag < CTS_LAG) begin
      lag <= lag + 1;
    end
  end
  assign cts = (lag == CTS_LAG);

  initial rxd = 1'b1;

  // stop=0 with zero data makes a break; the line then rests one bit at mark
  task automatic send_char(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (BIT_CYCLES) @(posedge clk);
    end
    if (!stop) begin
      rxd <= 1'b1;
      repeat (BIT_CYCLES) @(posedge clk);
    end
  endtask
endmodule

/* File: tb_serial_message_framer.sv */
// Purpose: self-checking bench for the serial message framer
// Assumes: peer runs at 4 clocks per bit; ms count shortened to 10 clocks
// Notes:   line lengths are sampled on the falling edge to avoid races
`timescale 1ns/1ps
module tb_serial_message_framer;
  localparam int unsigned MS  = 10;
  localparam int unsigned BIT = 4;
  logic        clk, resetn, psel, penable, pwrite, pready, pslverr;
  logic        cts, rxd, rts, txd, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  int          err_total, n_tests, n;

  serial_message_framer #(.MS_CYCLES(MS), .CAP_CYCLES(200)) dut (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cts(cts), .rxd(rxd), .rts(rts), .txd(txd));
  remote_serial_peer #(.BIT_CYCLES(BIT), .CTS_LAG(3)) peer (
    .clk(clk), .resetn(resetn), .rts(rts), .cts(cts), .rxd(rxd));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one edge passes after release so the next setup never lands on it
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      chk("pready", 1, 0);
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic hold_len(input logic sel_rts, input logic v, output int cnt);
    cnt = 0;
    while (((sel_rts ? rts : txd) === v) && cnt < 3000) begin
      @(negedge clk);
      cnt++;
    end
    if (cnt == 3000) begin
      chk("line wait", 0, 1);
      test_done();
    end
  endtask

  task automatic do_reset();
    resetn <= 1'b0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
  endtask

  task automatic t_static();
    apb(0, serial_framer_pkg::OFS_CTRL, 0);
    chk("ctrl", 8, rd[6:0]);
    apb(0, serial_framer_pkg::OFS_BITS, 0);
    chk("bit counts", 32'h000C_000C, rd);
    apb(0, serial_framer_pkg::OFS_RX_CFG, 0);
    chk("rx config", 32'h000C_0002, rd);
    apb(1, 8'h40, 32'h0000_00FF);
    chk("unmapped", 1, err);
    $display("static test done");
  endtask

  task automatic t_send();
    apb(1, serial_framer_pkg::OFS_BAUD, BIT);
    apb(1, serial_framer_pkg::OFS_BITS, 32'h0002_0003);
    apb(1, serial_framer_pkg::OFS_RTS_DLY, 32'h0001_0001);
    apb(1, serial_framer_pkg::OFS_CTRL, 32'h0000_0007);
    apb(1, serial_framer_pkg::OFS_TX_DATA, 32'h0000_00A5);
    hold_len(1, 0, n);
    hold_len(0, 1, n);
    chk("rts-on wait", 1, n >= MS);
    hold_len(0, 0, n);
    chk("break length", 3 * BIT, n);
    hold_len(0, 1, n);
    chk("idle length", 2 * BIT, n);
    hold_len(0, 0, n);
    chk("start bit", BIT, n);
    hold_len(1, 1, n);
    chk("rts-off hold", 1, n >= 9 * BIT + MS);
    apb(1, serial_framer_pkg::OFS_CTRL, 32'h0000_0006);
    apb(1, serial_framer_pkg::OFS_TX_DATA, 32'h0000_00FF);
    hold_len(0, 1, n);
    chk("no rts delay", 1, n < MS);
    chk("rts idle", 0, rts);
    $display("send test done");
  endtask

  task automatic rx_expect(input logic [8:0] v);
    repeat (2 * BIT) @(posedge clk);
    apb(0, serial_framer_pkg::OFS_RX_DATA, 0);
    chk("rx word", v, rd[8:0]);
  endtask

  task automatic t_receive();
    apb(1, serial_framer_pkg::OFS_CTRL, 32'h0000_0108);
    peer.send_char(8'h5A, 1);
    rx_expect(9'h15A);
    apb(1, serial_framer_pkg::OFS_RX_CFG, 32'h0003_0002);
    apb(1, serial_framer_pkg::OFS_CTRL, 32'h0000_0160);
    repeat (4 * BIT) @(posedge clk);
    peer.send_char(8'h11, 1);
    peer.send_char(8'h02, 1);
    repeat (4 * BIT) @(posedge clk);
    peer.send_char(8'h02, 1);
    peer.send_char(8'h33, 1);
    rx_expect(9'h102);
    rx_expect(9'h133);
    apb(1, serial_framer_pkg::OFS_CTRL, 32'h0000_0110);
    peer.send_char(8'h44, 1);
    peer.send_char(8'h00, 0);
    peer.send_char(8'h55, 1);
    rx_expect(9'h155);
    apb(0, serial_framer_pkg::OFS_RX_DATA, 0);
    chk("rx empty", 0, rd[8]);
    $display("receive test done");
  endtask

  initial begin
    err_total = 0;
    n_tests = 0;
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    do_reset();
    t_static();
    t_send();
    t_receive();
    do_reset();
    t_static();
    test_done();
  end
endmodule
